// ---- anps_regs.sv ----
// partner next-page view and expansion status registers over axi4-lite
// assumes the negotiation engine pulses pageValid once per received page
// assumes software uses byte addresses, four times the register index
`timescale 1ns/1ps
module anps_regs
	import anps_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire anps_pkg::anps_page_t pageIn,
	input wire logic pageValid,
	input wire anps_pkg::anps_status_t statusIn,
	input wire logic [anps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [anps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import anps_pkg::*;

	anps_page_t page_q, page_d;
	anps_status_t stat_q, stat_d;
	logic awSeen_q, awSeen_d, wSeen_q, wSeen_d, bValid_q, bValid_d;
	logic awReady_q, awReady_d, wReady_q, wReady_d;
	logic [1:0] bResp_q, bResp_d;
	logic [ADDR_W-1:0] awAddr_q, awAddr_d;
	logic arReady_q, arReady_d, rValid_q, rValid_d;
	logic [31:0] rData_q, rData_d;
	logic [1:0] rResp_q, rResp_d;
	logic readExpan, pageRxFlag;
	logic [15:0] partnerWord, expanWord;

	// page capture: the whole partner word follows the engine, software cannot write it
	always_comb begin
		page_d = page_q;
		stat_d = statusIn;
		if (pageValid)
			page_d = pageIn;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_q <= '0;
			stat_q <= '0;
		end else begin
			page_q <= page_d;
			stat_q <= stat_d;
		end
	end

	// the clear fires when the expansion read is accepted on the address channel
	assign readExpan = s_axi_arvalid && arReady_q && (s_axi_araddr == ADDR_EXPAN);

	anps_page_flag u_flag (
		.clk(clk),
		.rstn(rstn),
		.pageStrobe(pageValid),
		.clearStrobe(readExpan),
		.flag(pageRxFlag)
	);

	// register images; toggle bit already holds the inverted previous value
	always_comb begin
		partnerWord = '0;
		partnerWord[BIT_MORE_PAGES] = page_q.morePages;
		partnerWord[BIT_PARTNER_ACK] = page_q.ack;
		partnerWord[BIT_MSG_PAGE] = page_q.msgPage;
		partnerWord[BIT_COMPLY] = page_q.comply;
		partnerWord[BIT_TOGGLE] = page_q.toggle;
		partnerWord[CODE_W-1:0] = page_q.code;
		expanWord = '0;
		expanWord[BIT_PDF] = stat_q.parallelFault;
		expanWord[BIT_PARTNER_XP] = stat_q.partnerXp;
		expanWord[BIT_LOCAL_XP] = LOCAL_XP_RST;
		expanWord[BIT_PAGE_RX] = pageRxFlag;
		expanWord[BIT_PARTNER_AN] = stat_q.partnerAn;
	end

	// write channel: registers are read-only, so writes are answered and dropped
	always_comb begin
		awSeen_d = awSeen_q;
		wSeen_d = wSeen_q;
		awAddr_d = awAddr_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		if (s_axi_awvalid && !awSeen_q && !bValid_q) begin
			awSeen_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wSeen_q && !bValid_q)
			wSeen_d = 1'b1;
		if (awSeen_q && wSeen_q && !bValid_q) begin
			bValid_d = 1'b1;
			awSeen_d = 1'b0;
			wSeen_d = 1'b0;
			// mapped but read-only answers okay and changes nothing
			if (awAddr_q == ADDR_PARTNER || awAddr_q == ADDR_EXPAN)
				bResp_d = RESP_OKAY;
			else
				bResp_d = RESP_SLVERR;
		end
		if (bValid_q && s_axi_bready)
			bValid_d = 1'b0;
		// ready flags are registered from the next channel state, so the ports come
		// from flops yet open in the same cycle as a combinational decode would
		awReady_d = !awSeen_d && !bValid_d;
		wReady_d = !wSeen_d && !bValid_d;
	end

	// reset opens both write channels with no response pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awSeen_q <= 1'b0;
			wSeen_q <= 1'b0;
			awAddr_q <= '0;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
		end else begin
			awSeen_q <= awSeen_d;
			wSeen_q <= wSeen_d;
			awAddr_q <= awAddr_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			awReady_q <= awReady_d;
			wReady_q <= wReady_d;
		end
	end

	// read channel: one outstanding read, data registered one cycle after address
	always_comb begin
		arReady_d = arReady_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		if (s_axi_arvalid && arReady_q) begin
			arReady_d = 1'b0;
			rValid_d = 1'b1;
			rResp_d = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_PARTNER: rData_d = {16'h0000, partnerWord};
				ADDR_EXPAN: rData_d = {16'h0000, expanWord};
				default: begin
					rData_d = 32'h0000_0000;
					rResp_d = RESP_SLVERR;
				end
			endcase
		end
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
			arReady_d = 1'b1;
		end
	end

	// reset opens the read address channel with no data pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arReady_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= RESP_OKAY;
		end else begin
			arReady_q <= arReady_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
		end
	end

	// every bus output is a plain flop, so no input ripples straight back to the master
	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	// checks on the register images: each field follows the last page taken
	// and holds between pages, whatever the bus does
	page_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		pageValid |=> page_q.code == $past(pageIn.code))
		else $error("code not captured");
	msg_flag_a: assert property (@(posedge clk) disable iff (!rstn)
		pageValid |=> partnerWord[BIT_MSG_PAGE] == $past(pageIn.msgPage))
		else $error("message page flag not captured");
	comply_bit_a: assert property (@(posedge clk) disable iff (!rstn)
		pageValid |=> partnerWord[BIT_COMPLY] == $past(pageIn.comply))
		else $error("comply bit not captured");
	toggle_bit_a: assert property (@(posedge clk) disable iff (!rstn)
		pageValid |=> partnerWord[BIT_TOGGLE] == $past(pageIn.toggle))
		else $error("toggle bit not captured");
	more_pages_a: assert property (@(posedge clk) disable iff (!rstn)
		pageValid |=> {partnerWord[BIT_MORE_PAGES], partnerWord[BIT_PARTNER_ACK]}
			== $past({pageIn.morePages, pageIn.ack}))
		else $error("more pages or ack bit not captured");
	page_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!pageValid |=> $stable(page_q))
		else $error("partner word changed without a page");

	// expansion word: reserved bits read back as zero and the local bit as set, status one cycle late,
	// and the page flag shown as it stood before the clearing read
	expan_reserved_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_EXPAN
		|=> s_axi_rdata[31:BIT_PDF+1] == '0 && s_axi_rdata[BIT_LOCAL_XP])
		else $error("expansion fixed bits wrong on read");
	status_follow_a: assert property (@(posedge clk) disable iff (!rstn)
		##1 {expanWord[BIT_PDF], expanWord[BIT_PARTNER_XP]}
			== $past({statusIn.parallelFault, statusIn.partnerXp}))
		else $error("status levels not shown");
	an_able_a: assert property (@(posedge clk) disable iff (!rstn)
		##1 expanWord[BIT_PARTNER_AN] == $past(statusIn.partnerAn))
		else $error("partner autoneg bit not shown");
	read_clears_a: assert property (@(posedge clk) disable iff (!rstn)
		readExpan && !pageValid |=> !expanWord[BIT_PAGE_RX])
		else $error("read did not clear");
	flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!readExpan && !pageValid |=> $stable(pageRxFlag))
		else $error("page flag moved with no event");
	flag_read_a: assert property (@(posedge clk) disable iff (!rstn)
		readExpan |=> s_axi_rdata[BIT_PAGE_RX] == $past(pageRxFlag))
		else $error("page flag read back wrong");

	// read channel: one read at a time, answer a cycle after the address
	// and held until the master takes it
	read_answer_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	arready_take_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("second read taken while one is open");
	partner_read_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PARTNER
		|=> s_axi_rdata == {16'h0000, $past(partnerWord)})
		else $error("partner word read back wrong");
	rresp_ok_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_PARTNER
		|| s_axi_araddr == ADDR_EXPAN) |=> s_axi_rresp == RESP_OKAY)
		else $error("mapped read not okay");
	bad_addr_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr != ADDR_PARTNER && s_axi_araddr != ADDR_EXPAN
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	rdata_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped or changed");
	ar_block_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while data pending");
	read_done_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened");

	// write channel: writes are answered and dropped, okay on the two mapped words
	// and an error elsewhere
	write_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_bvalid && !pageValid |=> $stable(page_q))
		else $error("write changed page");
	write_answer_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	awready_take_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address open after being taken");
	wready_take_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data open after being taken");
	aw_block_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open while response pending");
	bresp_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	write_resp_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(s_axi_bvalid) |-> s_axi_bresp == ((awAddr_q == ADDR_PARTNER
		|| awAddr_q == ADDR_EXPAN) ? RESP_OKAY : RESP_SLVERR))
		else $error("write response code wrong");
	write_done_a: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");

	// scenarios the bench is meant to reach
	page_seen_c: cover property (@(posedge clk) disable iff (!rstn) pageValid ##[1:4] readExpan);
	flag_read_c: cover property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid && s_axi_rready && s_axi_rdata[BIT_PAGE_RX]);
	clash_c: cover property (@(posedge clk) disable iff (!rstn) pageValid && readExpan);
	write_c: cover property (@(posedge clk) disable iff (!rstn) s_axi_bvalid && s_axi_bready);
	bad_read_c: cover property (@(posedge clk) disable iff (!rstn) s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// ---- anps_pkg.sv ----
// package for the partner page status register bank
// assumes a 32-bit axi4-lite register bus and a 25 MHz single clock
package anps_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_IDX_PARTNER = 8'h05;
	localparam logic [ADDR_W-1:0] REG_IDX_EXPAN = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_PARTNER = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_EXPAN = 8'h18;
	localparam int BIT_MORE_PAGES = 15;
	localparam int BIT_PARTNER_ACK = 14;
	localparam int BIT_MSG_PAGE = 13;
	localparam int BIT_COMPLY = 12;
	localparam int BIT_TOGGLE = 11;
	localparam int CODE_W = 11;
	localparam int BIT_PDF = 4;
	localparam int BIT_PARTNER_XP = 3;
	localparam int BIT_LOCAL_XP = 2;
	localparam int BIT_PAGE_RX = 1;
	localparam int BIT_PARTNER_AN = 0;
	localparam logic [CODE_W-1:0] CODE_RST = 11'h000;
	localparam logic LOCAL_XP_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one received next page as the negotiation engine hands it over
	typedef struct packed {
		logic morePages;
		logic ack;
		logic msgPage;
		logic comply;
		logic toggle;
		logic [CODE_W-1:0] code;
	} anps_page_t;

	// partner and detection status levels
	typedef struct packed {
		logic parallelFault;
		logic partnerXp;
		logic partnerAn;
	} anps_status_t;
endpackage

// ---- anps_page_flag.sv ----
// sticky page-received flag, cleared by a register read
// assumes pageStrobe and clearStrobe are one-cycle pulses on clk
`timescale 1ns/1ps
module anps_page_flag
	import anps_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pageStrobe,
	input wire logic clearStrobe,
	output logic flag
);
	import anps_pkg::*;

	logic flag_q, flag_d;

	// a new page beats the read clear so no reception is lost
	always_comb begin
		flag_d = flag_q;
		if (clearStrobe)
			flag_d = 1'b0;
		if (pageStrobe)
			flag_d = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;

	set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
		pageStrobe |=> flag_q)
		else $error("page flag lost on same-cycle clear");
	clear_read_a: assert property (@(posedge clk) disable iff (!rstn)
		clearStrobe && !pageStrobe |=> !flag_q)
		else $error("page flag not cleared");
endmodule

// ---- anps_partner_model.sv ----
// far-side stand-in: the negotiation engine handing over received pages
// assumes the bench raises go for one cycle per page
`timescale 1ns/1ps
module anps_partner_model
	import anps_pkg::*;
(
	input wire logic go,
	input wire anps_pkg::anps_page_t page,
	input wire anps_pkg::anps_status_t levels,
	output anps_pkg::anps_page_t pageIn,
	output logic pageValid,
	output anps_pkg::anps_status_t statusIn
);
	// page lines mean nothing without the strobe, so they show the inverse then
	assign pageIn = go ? page : anps_page_t'(~page);
	assign pageValid = go;
	assign statusIn = levels;
endmodule

// ---- autoneg_partner_page_status_bench.sv ----
// self-checking bench for the partner page status registers
// assumes anps_regs and anps_partner_model are compiled first
`timescale 1ns/1ps
module autoneg_partner_page_status_bench;
	import anps_pkg::*;
	logic clk = 0, rstn = 0, go = 0;
	logic awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
	logic [7:0] awA = 0, arA = 0;
	logic [31:0] wD = 0, rD;
	logic awRdy, wRdy, bV, arRdy, rV;
	logic [1:0] bRsp, rRsp;
	logic [4:0] hs;
	anps_page_t pg = '0, pgIn;
	anps_status_t st = '0, stIn;
	logic pgV;
	int error_cnt = 0, n_compared = 0;
	assign hs = {rV, bV, arRdy, wRdy, awRdy};
	always #20 clk = ~clk;
	anps_partner_model pm_u (.go(go), .page(pg), .levels(st), .pageIn(pgIn),
		.pageValid(pgV), .statusIn(stIn));
	anps_regs dut_u (.clk(clk), .rstn(rstn), .pageIn(pgIn), .pageValid(pgV),
		.statusIn(stIn), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
		.s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRsp),
		.s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA),
		.s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
		.s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait: a handshake bit is judged at the falling edge, where it has settled,
	// and the task returns just after the rising edge that takes the transfer
	task automatic tick(input int k);
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			if (hs[k] === 1'b1) begin
				@(posedge clk);
				return;
			end
		end
		error_cnt++;
		summarize();
	endtask
	// hit fires a page on the very edge that takes the read address
	task automatic rd(input logic [7:0] a, input logic hit, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		arA <= a;
		arV <= 1;
		rR <= 1;
		go <= hit;
		tick(2);
		arV <= 0;
		go <= 0;
		tick(4);
		d = rD;
		r = rRsp;
		rR <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic awUp;
		logic wUp;
		awUp = 1'b1;
		wUp = 1'b1;
		@(posedge clk);
		awA <= a;
		wD <= v;
		awV <= 1;
		wV <= 1;
		bR <= 1;
		// each channel drops its valid just after the edge that took it
		for (int i = 0; i < 50 && (awUp || wUp); i++) begin
			@(negedge clk);
			if (awRdy === 1'b1)
				awUp = 1'b0;
			if (wRdy === 1'b1)
				wUp = 1'b0;
			@(posedge clk);
			awV <= awUp;
			wV <= wUp;
		end
		tick(3);
		r = bRsp;
		bR <= 0;
	endtask
	function automatic logic [31:0] expX(anps_status_t s, logic f);
		return {27'h0, s.parallelFault, s.partnerXp, 1'b1, f, s.partnerAn};
	endfunction
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		anps_page_t p;
		anps_status_t s;
		logic [7:0] wa [3];
		d = $urandom(53379);
		wa = '{ADDR_PARTNER, ADDR_EXPAN, 8'h1c};
		repeat (3) @(posedge clk);
		rstn <= 1;
		rd(ADDR_PARTNER, 0, d, r);
		chk("partner reset", d, 32'h0);
		rd(ADDR_EXPAN, 0, d, r);
		chk("expansion reset", d, 32'h4);
		// random pages, first one with every field set
		for (int k = 0; k < 20; k++) begin
			p = 16'($urandom);
			s = 3'($urandom);
			if (k == 0)
				p = '1;
			@(posedge clk);
			pg <= p;
			st <= s;
			go <= 1;
			@(posedge clk);
			go <= 0;
			rd(ADDR_PARTNER, 0, d, r);
			chk("partner word", d, {16'h0, p});
			rd(ADDR_EXPAN, 0, d, r);
			chk("expansion", d, expX(s, 1));
			rd(ADDR_EXPAN, 0, d, r);
			chk("flag cleared", d, expX(s, 0));
		end
		// writes change nothing; unmapped places answer with an error
		foreach (wa[j]) begin
			wr(wa[j], 32'hffffffff, r);
			chk("bresp", r, (j == 2) ? RESP_SLVERR : RESP_OKAY);
			rd(wa[j], 0, d, r);
			chk("rresp", r, (j == 2) ? RESP_SLVERR : RESP_OKAY);
			chk("after write", d, (j == 0) ? {16'h0, p} : (j == 1) ? expX(s, 0) : 0);
		end
		// a page landing on the clearing read must survive it
		rd(ADDR_EXPAN, 1, d, r);
		chk("pre-clear", d, expX(s, 0));
		rd(ADDR_EXPAN, 0, d, r);
		chk("kept flag", d, expX(s, 1));
		summarize();
	end
endmodule
